// >>> rtl/phase_combo_pkg.sv
// Purpose: Shared constants for closed-loop phase offset and combo steering
// Assumes: Offsets in 50 ps units, frequency words in two's complement
// Notes:   Channel SYS_CH plays the system timing loop inside a combo group
package phase_combo_pkg;
  localparam int IN_NUM   = 8;             // Reference inputs
  localparam int IN_SEL_W = 3;
  localparam int CH_NUM   = 3;             // Channels in one combo group
  localparam int CH_SEL_W = 2;
  localparam int PHASE_W  = 32;            // Offset and error width, 50 ps units
  localparam int SUM_W    = PHASE_W + 1;   // Channel plus input offset
  localparam int ERR_W    = PHASE_W + 2;   // Sum plus detector error
  localparam int FCW_W    = 42;            // Frequency control word
  localparam int QL_W     = 4;             // Clock quality level
  localparam int PPS_W    = 32;            // Pulse shift in ns

  localparam logic [CH_SEL_W-1:0] NO_SRC = 2'h3;
  localparam logic [CH_SEL_W-1:0] SYS_CH = 2'h2;

  localparam int CLK_MHZ       = 40;
  localparam int UPDATE_US     = 1000;
  localparam int UPDATE_CYCLES = UPDATE_US * CLK_MHZ;

  localparam int KP_SHIFT = 4;             // Proportional gain as a shift
  localparam logic signed [ERR_W-1:0] PHASE_CLAMP = 34'sh0000000014;
  localparam logic signed [PPS_W-1:0] PPS_LIMIT_NS = 32'sh1dcd6500;

  localparam logic signed [SUM_W-1:0] APPLIED_RST = '0;
  localparam logic signed [FCW_W-1:0] FCW_RST     = '0;
endpackage

// >>> rtl/loop_filter.sv
// Purpose: Proportional-integral loop filter for one timing channel
// Assumes: en is a one-cycle pulse at the loop update rate
// Notes:   No saturation; callers keep error within a sane range
`timescale 1ns/1ps
module loop_filter
  import phase_combo_pkg::*;
(
  input  wire logic                    clk_i,    // System clock
  input  wire logic                    rst_n_i,  // Synchronised reset, low
  input  wire logic                    en_i,     // Loop update pulse
  input  wire logic signed [ERR_W-1:0] err_i,    // Phase error plus offset
  output logic signed [FCW_W-1:0]      fcw_o     // Filtered frequency word
);
  logic signed [FCW_W-1:0] integ_q;
  logic signed [FCW_W-1:0] integ_d;
  logic signed [FCW_W-1:0] fcw_d;
  logic signed [FCW_W-1:0] err_ext;

  always_comb begin
    err_ext = FCW_W'(err_i);
    integ_d = integ_q;
    fcw_d   = fcw_o;
    if (en_i) begin
      integ_d = FCW_W'(integ_q + err_ext);
      fcw_d   = FCW_W'(integ_d + (err_ext <<< KP_SHIFT));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      integ_q <= FCW_RST;
      fcw_o   <= FCW_RST;
    end else begin
      integ_q <= integ_d;
      fcw_o   <= fcw_d;
    end
  end
endmodule

// >>> rtl/phase_combo_top.sv
// Purpose: Closed-loop phase offset and combo-mode frequency steering
// Assumes: All inputs but RST_B_I synchronous to REF_CLK_I, offsets held by outside logic
// Notes:   Every update uses the offsets present at the update pulse
//
// Operation
// - Each reference input carries its own writable phase offset.
// - Each channel carries its own offset, independent of active input.
// - Applied offset is channel offset plus active input's offset.
// - A change of active input recomputes and applies the offset.
// - Applied offset adds to detector error and feeds the loop filter, except while the reference is suppressed.
// - One input offset is shared by all channels using that input.
// - Combo group holds up to three channels, one usually locked.
// - A source channel may drive up to two others, system loop included.
// - Receiving channel acts as DCO, externally steered or tracking source.
// - All combo frequency changes pass through at least one loop filter.
// - Reference transients are clamped or reference suppressed by quality.
// - Pulse-per-second output shifts by up to half a second either way.
// - Combo contributions add on top of the written frequency word.
`timescale 1ns/1ps
module phase_combo_top
  import phase_combo_pkg::*;
#(
  parameter int UPDATE_CYCLES_P = UPDATE_CYCLES  // Cycles per loop update
)(
  input  wire logic                       REF_CLK_I,                 // 40 MHz clock
  input  wire logic                       RST_B_I,                   // Async reset, low
  input  wire logic signed [PHASE_W-1:0]  IN_OFFSET_I     [IN_NUM],  // Per-input offset
  input  wire logic signed [PHASE_W-1:0]  CH_OFFSET_I     [CH_NUM],  // Per-channel offset
  input  wire logic [IN_SEL_W-1:0]        ACTIVE_REF_I    [CH_NUM],  // Active input
  input  wire logic signed [PHASE_W-1:0]  PHASE_ERR_I     [CH_NUM],  // Detector error
  input  wire logic [CH_NUM-1:0]          DCO_MODE_I,                // Channel runs as DCO
  input  wire logic signed [FCW_W-1:0]    WRITE_FCW_I     [CH_NUM],  // Written frequency
  input  wire logic                       COMBO_EN_I,                // Combo mode on
  input  wire logic [CH_SEL_W-1:0]        COMBO_SRC_I     [CH_NUM],  // Source channel
  input  wire logic [QL_W-1:0]            SSM_QL_I        [CH_NUM],  // Active ref quality
  input  wire logic [QL_W-1:0]            SSM_QL_MAX_I,              // Worst allowed level
  input  wire logic                       CLAMP_MODE_I,              // 1 clamp, 0 suppress
  input  wire logic signed [PPS_W-1:0]    PPS_SHIFT_I,               // Requested shift ns
  output logic signed [SUM_W-1:0]         APPLIED_OFFSET_O [CH_NUM], // Applied offset
  output logic signed [FCW_W-1:0]         FCW_O           [CH_NUM],  // Channel frequency
  output logic [CH_NUM-1:0]               SWITCHOVER_O,              // Input change pulse
  output logic [CH_NUM-1:0]               REF_SUPPRESSED_O,          // Ref ignored level
  output logic                            UPDATE_O,                  // Loop update pulse
  output logic signed [PPS_W-1:0]         PPS_SHIFT_O                // Applied shift ns
);
  // Release synchroniser; only the second flop is used downstream
  logic rst_meta_q;
  logic rst_n;
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // Loop update divider
  logic [31:0] div_q;
  logic [31:0] div_d;
  logic        upd_d;
  always_comb begin
    upd_d = (div_q == 32'(UPDATE_CYCLES_P - 1));
    div_d = upd_d ? 32'h0 : div_q + 32'h1;
  end
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      div_q    <= 32'h0;
      UPDATE_O <= 1'b0;
    end else begin
      div_q    <= div_d;
      UPDATE_O <= upd_d;
    end
  end

  // Combo source is legal only when enabled, not NO_SRC and not the channel itself
  function automatic logic src_ok(input logic en, input logic [CH_SEL_W-1:0] src,
                                  input int ch);
    src_ok = en && (src != NO_SRC) && (src != CH_SEL_W'(ch));
  endfunction

  logic signed [FCW_W-1:0] filt_fcw [CH_NUM];
  logic signed [SUM_W-1:0] applied_d [CH_NUM];
  logic signed [ERR_W-1:0] loop_err  [CH_NUM];
  logic signed [FCW_W-1:0] fcw_d     [CH_NUM];
  logic [IN_SEL_W-1:0]     ref_q     [CH_NUM];
  logic [CH_NUM-1:0]       ref_seen_q;

  genvar c;
  generate
    for (c = 0; c < CH_NUM; c++) begin : g_ch
      logic signed [ERR_W-1:0] pd_err;
      logic signed [FCW_W-1:0] combo_add;
      logic                    suppress;
      logic                    switch_d;

      always_comb begin
        // One shared table entry per input, whatever channel reads it
        applied_d[c] = SUM_W'(CH_OFFSET_I[c]) + SUM_W'(IN_OFFSET_I[ACTIVE_REF_I[c]]);
        suppress = 1'b0;
        pd_err   = DCO_MODE_I[c] ? '0 : ERR_W'(PHASE_ERR_I[c]);
        if (CLAMP_MODE_I) begin
          if (pd_err > PHASE_CLAMP) begin
            pd_err = PHASE_CLAMP;
          end else if (pd_err < -PHASE_CLAMP) begin
            pd_err = -PHASE_CLAMP;
          end
        end else if (!DCO_MODE_I[c] && (SSM_QL_I[c] > SSM_QL_MAX_I)) begin
          // Poor quality: hold frequency rather than chase the transient
          suppress = 1'b1;
          pd_err   = '0;
        end
        // Offset enters exactly where a detector error would
        loop_err[c] = suppress ? '0 : ERR_W'(pd_err + ERR_W'(applied_d[c]));
        // Source word is already filtered; only the written word of a DCO channel reaches the output unfiltered
        combo_add = '0;
        if (src_ok(COMBO_EN_I, COMBO_SRC_I[c], c)) begin
          combo_add = filt_fcw[COMBO_SRC_I[c]];
        end
        fcw_d[c] = FCW_W'(filt_fcw[c] + combo_add
                   + (DCO_MODE_I[c] ? WRITE_FCW_I[c] : FCW_RST));
        switch_d = ref_seen_q[c] && (ACTIVE_REF_I[c] != ref_q[c]);
      end

      always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
          APPLIED_OFFSET_O[c] <= APPLIED_RST;
          FCW_O[c]            <= FCW_RST;
          ref_q[c]            <= '0;
          ref_seen_q[c]       <= 1'b0;
          SWITCHOVER_O[c]     <= 1'b0;
          REF_SUPPRESSED_O[c] <= 1'b0;
        end else begin
          SWITCHOVER_O[c] <= 1'b0;
          if (UPDATE_O) begin
            APPLIED_OFFSET_O[c] <= applied_d[c];
            FCW_O[c]            <= fcw_d[c];
            ref_q[c]            <= ACTIVE_REF_I[c];
            ref_seen_q[c]       <= 1'b1;
            SWITCHOVER_O[c]     <= switch_d;
            REF_SUPPRESSED_O[c] <= suppress;
          end
        end
      end

      loop_filter u_filt (
        .clk_i   (REF_CLK_I),
        .rst_n_i (rst_n),
        .en_i    (UPDATE_O),
        .err_i   (loop_err[c]),
        .fcw_o   (filt_fcw[c])
      );
    end
  endgenerate

  // Pulse shift limited to half a second each way
  logic signed [PPS_W-1:0] pps_d;
  always_comb begin
    pps_d = PPS_SHIFT_I;
    if (PPS_SHIFT_I > PPS_LIMIT_NS) begin
      pps_d = PPS_LIMIT_NS;
    end else if (PPS_SHIFT_I < -PPS_LIMIT_NS) begin
      pps_d = -PPS_LIMIT_NS;
    end
  end
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      PPS_SHIFT_O <= '0;
    end else begin
      PPS_SHIFT_O <= pps_d;
    end
  end
endmodule

// >>> sim/phase_combo_checker.sv
// Purpose: Port checker for phase_combo_top
// Assumes: Bound from the bench top, one clock domain
// Notes:   Guard counter skips the reset synchroniser delay
`timescale 1ns/1ps
module phase_combo_checker
  import phase_combo_pkg::*;
#(parameter int UPDATE_CYCLES_P = 8)(
  input wire logic                      REF_CLK_I, RST_B_I, CLAMP_MODE_I, UPDATE_O,
  input wire logic signed [PHASE_W-1:0] IN_OFFSET_I [IN_NUM], CH_OFFSET_I [CH_NUM],
  input wire logic [IN_SEL_W-1:0]       ACTIVE_REF_I [CH_NUM],
  input wire logic [CH_NUM-1:0]         DCO_MODE_I, SWITCHOVER_O, REF_SUPPRESSED_O,
  input wire logic [QL_W-1:0]           SSM_QL_I [CH_NUM], SSM_QL_MAX_I,
  input wire logic signed [PPS_W-1:0]   PPS_SHIFT_I, PPS_SHIFT_O,
  input wire logic signed [SUM_W-1:0]   APPLIED_OFFSET_O [CH_NUM],
  input wire logic signed [FCW_W-1:0]   FCW_O [CH_NUM]
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);
  logic [2:0] ok_q;
  logic seen_q;
  int gap_q;
  logic [IN_SEL_W-1:0] last_q [CH_NUM];
  logic [CH_NUM-1:0] chg_q, supp;
  logic signed [SUM_W-1:0] exp_sum [CH_NUM];
  logic signed [PPS_W-1:0] pps_c;
  always_comb begin
    pps_c = PPS_SHIFT_I > PPS_LIMIT_NS ? PPS_LIMIT_NS : PPS_SHIFT_I;
    pps_c = PPS_SHIFT_I < -PPS_LIMIT_NS ? -PPS_LIMIT_NS : pps_c;
    for (int c = 0; c < CH_NUM; c++) begin
      exp_sum[c] = SUM_W'(CH_OFFSET_I[c]) + SUM_W'(IN_OFFSET_I[ACTIVE_REF_I[c]]);
      supp[c] = !CLAMP_MODE_I && !DCO_MODE_I[c] && (SSM_QL_I[c] > SSM_QL_MAX_I);
    end
  end
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ok_q <= '0;
      seen_q <= 1'b0;
      gap_q <= 0;
      chg_q <= '0;
      for (int c = 0; c < CH_NUM; c++) last_q[c] <= '0;
    end else begin
      if (ok_q != 3'h7) ok_q <= ok_q + 3'h1;
      gap_q <= UPDATE_O ? 0 : gap_q + 1;
      if (UPDATE_O) begin
        seen_q <= 1'b1;
        for (int c = 0; c < CH_NUM; c++) chg_q[c] <= seen_q && ACTIVE_REF_I[c] != last_q[c];
        for (int c = 0; c < CH_NUM; c++) last_q[c] <= ACTIVE_REF_I[c];
      end
    end
  end
  property p_period; seen_q |-> UPDATE_O == (gap_q == UPDATE_CYCLES_P - 1); endproperty
  a_period: assert property (p_period) else $error("update spacing wrong");
  property p_switch; SWITCHOVER_O == ($past(UPDATE_O) ? chg_q : '0); endproperty
  a_switch: assert property (p_switch) else $error("switchover pulse wrong");
  property p_supp; $past(UPDATE_O) |-> REF_SUPPRESSED_O == $past(supp); endproperty
  a_supp: assert property (p_supp) else $error("suppression wrong");
  property p_supp_hold; !$past(UPDATE_O) |-> $stable(REF_SUPPRESSED_O); endproperty
  a_supp_hold: assert property (p_supp_hold) else $error("suppression moved");
  property p_pps; ok_q == 3'h7 |-> PPS_SHIFT_O == $past(pps_c); endproperty
  a_pps: assert property (p_pps) else $error("pulse shift wrong");
  for (genvar c = 0; c < CH_NUM; c++) begin : g_ch
    property p_applied; UPDATE_O |=> APPLIED_OFFSET_O[c] == $past(exp_sum[c]); endproperty
    a_applied: assert property (p_applied) else $error("applied offset wrong");
    property p_app_hold; !UPDATE_O |=> $stable(APPLIED_OFFSET_O[c]); endproperty
    a_app_hold: assert property (p_app_hold) else $error("offset moved");
    property p_fcw_hold; !$past(UPDATE_O) |-> $stable(FCW_O[c]); endproperty
    a_fcw_hold: assert property (p_fcw_hold) else $error("word moved");
  end
endmodule

// >>> sim/servo_model.sv
// Purpose: External servo writing frequency words
// Assumes: Words held between servo writes
// Notes:   Constant words keep filter expectations exact
`timescale 1ns/1ps
module servo_model
  import phase_combo_pkg::*;
#(parameter logic signed [FCW_W-1:0] STEP = 42'sh000000001f4)(
  output logic signed [FCW_W-1:0] fcw_o [CH_NUM]  // Written words
);
  always_comb for (int c = 0; c < CH_NUM; c++) fcw_o[c] = STEP * FCW_W'(c);
endmodule

// >>> sim/phase_combo_top_test.sv
// Purpose: Self-checking bench for phase_combo_top
// Assumes: Loop update shortened to 8 cycles
// Notes:   Filter figures follow the proportional-integral walk
`timescale 1ns/1ps
module phase_combo_top_test;
  import phase_combo_pkg::*;
  logic clk = 0, rst_b = 0, combo = 1, clamp = 1, upd;
  logic signed [PHASE_W-1:0] in_off [IN_NUM] = '{default: '0};
  logic signed [PHASE_W-1:0] ch_off [CH_NUM] = '{default: '0};
  logic signed [PHASE_W-1:0] perr [CH_NUM] = '{32'sh4, 32'sh0, 32'sh0};
  logic [IN_SEL_W-1:0] act [CH_NUM] = '{default: '0};
  logic [CH_SEL_W-1:0] src [CH_NUM] = '{NO_SRC, 2'h0, 2'h0};
  logic [QL_W-1:0] ql [CH_NUM] = '{default: '0};
  logic [QL_W-1:0] qlmax = 4'h3;
  logic [CH_NUM-1:0] dco = 3'h2, sw, supp;
  logic signed [PPS_W-1:0] pps_i = '0, pps_o;
  logic signed [FCW_W-1:0] wfcw [CH_NUM], fcw [CH_NUM];
  logic signed [SUM_W-1:0] applied [CH_NUM];
  int num_errors = 0, samples_checked = 0, cycles = 0;
  always #12.5 clk = ~clk;
  servo_model servo_model_i (.fcw_o(wfcw));
  phase_combo_top #(.UPDATE_CYCLES_P(8)) phase_combo_top_i (.REF_CLK_I(clk), .RST_B_I(rst_b),
    .IN_OFFSET_I(in_off), .CH_OFFSET_I(ch_off), .ACTIVE_REF_I(act), .PHASE_ERR_I(perr),
    .DCO_MODE_I(dco), .WRITE_FCW_I(wfcw), .COMBO_EN_I(combo), .COMBO_SRC_I(src),
    .SSM_QL_I(ql), .SSM_QL_MAX_I(qlmax), .CLAMP_MODE_I(clamp), .PPS_SHIFT_I(pps_i),
    .APPLIED_OFFSET_O(applied), .FCW_O(fcw), .SWITCHOVER_O(sw), .REF_SUPPRESSED_O(supp),
    .UPDATE_O(upd), .PPS_SHIFT_O(pps_o));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_upd();
    int n = 0;
    @(negedge clk);
    while (upd !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) num_errors++;
    @(negedge clk);
  endtask
  task automatic t_combo();
    for (int k = 0; k < 3; k++) begin
      wait_upd();
      check(fcw[0], k == 0 ? 0 : 64 + 4 * k);
      check(fcw[1], (k == 0 ? 0 : 64 + 4 * k) + 42'sh1f4);
      check(fcw[2], k == 0 ? 0 : 64 + 4 * k);
    end
    $display("combo test done");
  endtask
  task automatic t_offsets();
    @(posedge clk);
    for (int i = 0; i < IN_NUM; i++) in_off[i] <= (i == 5) ? 32'sh7fffffff : 32'(i * 256 - 768);
    ch_off <= '{32'sh7fffffff, -32'sh5, 32'sh10};
    act <= '{3'h5, 3'h5, 3'h2};
    wait_upd();
    check(applied[0], 33'sh0fffffffe);
    check(applied[1], 33'sh07ffffffa);
    check(applied[2], 33'sh1ffffff10);
    @(posedge clk);
    act[1] <= 3'h3;
    wait_upd();
    check(sw, 3'h2);
    check(applied[1], -33'sh5);
    $display("offset test done");
  endtask
  task automatic t_suppress();
    @(posedge clk);
    clamp <= 1'b0;
    ql <= '{4'h5, 4'h9, 4'h1};
    wait_upd();
    check(supp, 3'h1);
    $display("suppress test done");
  endtask
  task automatic t_pps(input logic signed [PPS_W-1:0] v, input logic signed [PPS_W-1:0] e);
    @(posedge clk);
    pps_i <= v;
    @(posedge clk);
    @(negedge clk);
    check(pps_o, e);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_combo();
    t_offsets();
    t_suppress();
    t_pps(32'sh23c34600, 32'sh1dcd6500);
    t_pps(-32'sh23c34600, -32'sh1dcd6500);
    t_pps(32'sh1dcd6500, 32'sh1dcd6500);
    print_verdict();
  end
endmodule
bind phase_combo_top phase_combo_checker #(.UPDATE_CYCLES_P(UPDATE_CYCLES_P)) phase_combo_checker_i (.*);
